// file: inc/eal_pkg.sv
// Purpose: shared constants for the e1 alarm and loopback control block
// Assumes: 100 MHz system clock
// Notes: register map, field positions, reset values and timing counts
`default_nettype none
package eal_pkg;
    // register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_NSTAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_TEST = 8'h10;
    localparam logic [7:0] ADDR_TOD = 8'h14;
    localparam logic [7:0] ADDR_DATE = 8'h18;
    localparam logic [7:0] ADDR_ERRCNT = 8'h1C;
    // control field positions
    localparam int C_YELLOW_EN = 0;
    localparam int C_ALT_CODE = 1;
    localparam int C_V54_EN = 2;
    localparam int C_DTELOSS_LO = 3; // two bits
    localparam int C_TIMING_LO = 5;  // two bits
    localparam int C_CRC4 = 7;
    localparam int C_MODEM = 8;
    localparam int C_BLOCK_ALL = 9;
    localparam int C_ALM_EN_LO = 10; // four bits
    localparam int C_LAMP = 14;
    localparam logic [31:0] CTRL_RESET = 32'h0000_3C09;
    // dte loss modes
    localparam logic [1:0] DTE_NONE = 2'h0;
    localparam logic [1:0] DTE_RTS = 2'h1;
    localparam logic [1:0] DTE_DTR = 2'h2;
    // timing sources
    localparam logic [1:0] TSRC_NET = 2'h0;
    localparam logic [1:0] TSRC_INT = 2'h1;
    localparam logic [1:0] TSRC_PORT = 2'h2;
    // test lengths
    localparam logic [1:0] TLEN_15 = 2'h0;
    localparam logic [1:0] TLEN_1 = 2'h1;
    localparam logic [1:0] TLEN_60 = 2'h2;
    localparam logic [1:0] TLEN_UNL = 2'h3;
    // status and event bit positions
    localparam int S_LOS = 0;
    localparam int S_LOF = 1;
    localparam int S_AIS = 2;
    localparam int S_RAI = 3;
    localparam int S_TESTEND = 4;
    localparam int S_DIAL = 5;
    localparam int S_NETLPBK = 6;
    localparam int S_PLLPBK = 7;
    // power-up clock values
    localparam logic [31:0] TOD_RESET = 32'h0000_0000;
    localparam logic [31:0] DATE_RESET = 32'h0001_0101;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int MIN_S = 60;
    localparam longint MIN_CYC = longint'(MIN_S) * CLK_MHZ * 1000000;
endpackage : eal_pkg
`default_nettype wire

// file: logic/eal_ctrl.sv
// Purpose: alarm response, loopback gating, test timing and dial-out control
// Assumes: all inputs synchronous to clk_sys
// Notes: registers on a plain strobe port, read data one cycle later
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - loss of signal or frame sends remote alarm toward network
// - while los/lof persists report it and drop clear-to-send
// - unframed all-ones drops line-signal-detect and flags service alarm
// - received remote alarm, when enabled, reported and drops clear-to-send
// - test runs 1, 15, 60 minutes or unlimited; the limited lengths end themselves
// - network loopup accepted only for matching configured code set
// - payload loopback needs v.54 option and assigned bandwidth
// - dte loss selectable, rts default; none keeps clear-to-send on
// - transmit timing from network, internal oscillator or data port
// - crc-4 counts crc errors and violations; unstructured violations only
// - dial out needs modem, no blocking, alarm enabled; two numbers
// - power-up loads default time-of-day and date
// - lamp test lights every ledOut indicator, but not testActive
module eal_ctrl #(
    parameter longint MIN_CYCLES = eal_pkg::MIN_CYC,
    parameter int LED_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic irq,
    // network receiver status
    input wire logic netLos,
    input wire logic netLof,
    input wire logic netAis,
    input wire logic netRaiRx,
    input wire logic netLoopupStd,
    input wire logic netLoopupAlt,
    input wire logic netLoopdown,
    input wire logic netV54Up,
    input wire logic netV54Down,
    input wire logic payloadHasBw,
    input wire logic crcErr,
    input wire logic codeViol,
    // data port
    input wire logic dteRts,
    input wire logic dteDtr,
    output logic dteCts,
    output logic dteRlsd,
    // network transmit and loopbacks
    output logic netRaiTx,
    output logic netLoopback,
    output logic payloadLoopback,
    output logic [1:0] txTimingSel,
    // dial-out
    output logic dialReq,
    output logic dialNumSel,
    input wire logic dialDone,
    // front panel
    output logic [LED_W-1:0] ledOut,
    input wire logic [LED_W-1:0] ledNormal,
    output logic testActive
);
    typedef enum logic [1:0] {EAL_IDLE = 2'b00, EAL_RUN = 2'b01, EAL_DONE = 2'b11} eal_test_t;
    typedef enum logic [1:0] {EAL_DIDLE = 2'b00, EAL_DIAL1 = 2'b01, EAL_DIAL2 = 2'b11} eal_dial_t;

    logic [31:0] ctrl, tod, date;
    logic [7:0] irqStat, irqMask, events;
    logic [15:0] errCnt;
    logic [1:0] testLen, dteMode;
    logic testStart, testStop, minTick, testEnd, dialTrig, raiSeen, dteLost, wrCtrl;
    eal_test_t testState, next_testState;
    eal_dial_t dialState;
    logic [39:0] minCnt;
    logic [5:0] minutes, limitMin;
    logic [3:0] alarmNow, alarmPrev, alarmRise;

    // ------------------------------------------------------------
    // alarm evaluation
    // ------------------------------------------------------------
    // qualified alarm levels and their rising edges
    assign raiSeen = netRaiRx && ctrl[eal_pkg::C_YELLOW_EN];
    assign alarmNow = {raiSeen, netAis, netLof, netLos};
    assign alarmRise = alarmNow & ~alarmPrev;
    assign dteMode = ctrl[eal_pkg::C_DTELOSS_LO +: 2];
    assign dteLost = (dteMode == eal_pkg::DTE_RTS) ? !dteRts :
                     (dteMode == eal_pkg::DTE_DTR) ? !dteDtr : 1'b0;
    assign wrCtrl = regWr && (regAddr == eal_pkg::ADDR_CTRL);

    // edge history of alarm levels
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alarmPrev <= 4'h0;
        end else begin
            alarmPrev <= alarmNow;
        end
    end

    // line and data port outputs
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            netRaiTx <= 1'b0;
            dteCts <= 1'b0;
            dteRlsd <= 1'b0;
            txTimingSel <= eal_pkg::TSRC_NET;
        end else begin
            netRaiTx <= netLos || netLof;
            dteCts <= !(netLos || netLof || raiSeen || dteLost);
            dteRlsd <= !netAis;
            txTimingSel <= ctrl[eal_pkg::C_TIMING_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // loopback control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            netLoopback <= 1'b0;
            payloadLoopback <= 1'b0;
        end else begin
            // loopup only on matching code set
            if (ctrl[eal_pkg::C_ALT_CODE] ? netLoopupAlt : netLoopupStd) begin
                netLoopback <= 1'b1;
            end else if (netLoopdown) begin
                netLoopback <= 1'b0;
            end
            if (netV54Up && ctrl[eal_pkg::C_V54_EN] && payloadHasBw) begin
                payloadLoopback <= 1'b1;
            end else if (netV54Down || !payloadHasBw) begin
                payloadLoopback <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // diagnostic test timer
    // ------------------------------------------------------------
    assign testStart = regWr && (regAddr == eal_pkg::ADDR_TEST) && regWdata[0];
    assign testStop = regWr && (regAddr == eal_pkg::ADDR_TEST) && regWdata[1];
    assign minTick = (testState == EAL_RUN) && (minCnt == 40'(MIN_CYCLES - 1));
    assign limitMin = (testLen == eal_pkg::TLEN_1) ? 6'd1 :
                      (testLen == eal_pkg::TLEN_15) ? 6'd15 : 6'd60;
    // limited lengths end on their own
    assign testEnd = minTick && (testLen != eal_pkg::TLEN_UNL) &&
                     (minutes == limitMin - 6'd1);

    // test state transitions
    always_comb begin
        next_testState = testState;
        case (testState)
            EAL_IDLE: begin
                if (testStart) next_testState = EAL_RUN;
            end
            EAL_RUN: begin
                if (testStop || testEnd) next_testState = EAL_DONE;
            end
            EAL_DONE: begin
                if (testStart) next_testState = EAL_RUN;
                else next_testState = EAL_IDLE;
            end
            default: next_testState = EAL_IDLE;
        endcase
    end

    // test state and minute counters
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            testState <= EAL_IDLE;
            testLen <= eal_pkg::TLEN_15;
            minCnt <= 40'h0;
            minutes <= 6'h0;
            testActive <= 1'b0;
        end else begin
            testState <= next_testState;
            testActive <= (next_testState == EAL_RUN);
            if (testStart && testState != EAL_RUN) begin
                testLen <= regWdata[3:2];
                minCnt <= 40'h0;
                minutes <= 6'h0;
            end else if (minTick) begin
                minCnt <= 40'h0;
                if (minutes != 6'd63) minutes <= minutes + 6'd1;
            end else if (testState == EAL_RUN) begin
                minCnt <= minCnt + 40'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // error counting
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            errCnt <= 16'h0;
        end else if (regWr && regAddr == eal_pkg::ADDR_ERRCNT) begin
            errCnt <= 16'h0;
        end else begin
            // crc errors only in crc-4 mode
            if ((codeViol || (crcErr && ctrl[eal_pkg::C_CRC4])) && errCnt != 16'hFFFF) begin
                errCnt <= errCnt + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // alarm dial-out
    // ------------------------------------------------------------
    // all three conditions gate the dial
    assign dialTrig = ctrl[eal_pkg::C_MODEM] && !ctrl[eal_pkg::C_BLOCK_ALL] &&
                      |(alarmRise & ctrl[eal_pkg::C_ALM_EN_LO +: 4]);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dialState <= EAL_DIDLE;
            dialReq <= 1'b0;
            dialNumSel <= 1'b0;
        end else begin
            case (dialState)
                EAL_DIDLE: begin
                    if (dialTrig) begin
                        dialState <= EAL_DIAL1;
                        dialReq <= 1'b1;
                        dialNumSel <= 1'b0;
                    end
                end
                EAL_DIAL1: begin
                    if (dialDone) begin
                        dialState <= EAL_DIAL2;
                        dialNumSel <= 1'b1;
                    end
                end
                EAL_DIAL2: begin
                    if (dialDone) begin
                        dialState <= EAL_DIDLE;
                        dialReq <= 1'b0;
                        dialNumSel <= 1'b0;
                    end
                end
                default: dialState <= EAL_DIDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // front panel
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ledOut <= '0;
        end else begin
            ledOut <= ctrl[eal_pkg::C_LAMP] ? {LED_W{1'b1}} : ledNormal;
        end
    end

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    assign events = {payloadLoopback && !ctrl[eal_pkg::C_V54_EN], 1'b0, dialTrig, testEnd,
                     alarmRise};

    // control, mask and clock registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= eal_pkg::CTRL_RESET;
            irqMask <= 8'h00;
            tod <= eal_pkg::TOD_RESET;
            date <= eal_pkg::DATE_RESET;
        end else if (regWr) begin
            if (wrCtrl) ctrl <= regWdata;
            else if (regAddr == eal_pkg::ADDR_IRQ_MASK) irqMask <= regWdata[7:0];
            else if (regAddr == eal_pkg::ADDR_TOD) tod <= regWdata;
            else if (regAddr == eal_pkg::ADDR_DATE) date <= regWdata;
        end
    end

    // sticky status, set wins over write-one-clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqStat <= 8'h00;
        end else if (regWr && regAddr == eal_pkg::ADDR_IRQ_STAT) begin
            irqStat <= (irqStat & ~regWdata[7:0]) | events;
        end else begin
            irqStat <= irqStat | events;
        end
    end

    // interrupt level output
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irqStat | events) & irqMask);
        end
    end

    // read data one cycle after strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 32'h0;
        end else if (regRd) begin
            if (regAddr == eal_pkg::ADDR_CTRL) regRdata <= ctrl;
            else if (regAddr == eal_pkg::ADDR_NSTAT)
                regRdata <= {24'h0, payloadLoopback, netLoopback, dialReq,
                             testState == EAL_RUN, alarmNow};
            else if (regAddr == eal_pkg::ADDR_IRQ_STAT) regRdata <= {24'h0, irqStat};
            else if (regAddr == eal_pkg::ADDR_IRQ_MASK) regRdata <= {24'h0, irqMask};
            else if (regAddr == eal_pkg::ADDR_TEST)
                regRdata <= {16'h0, 2'h0, minutes, 4'h0, testLen, testState};
            else if (regAddr == eal_pkg::ADDR_TOD) regRdata <= tod;
            else if (regAddr == eal_pkg::ADDR_DATE) regRdata <= date;
            else if (regAddr == eal_pkg::ADDR_ERRCNT) regRdata <= {16'h0, errCnt};
            else regRdata <= 32'h0;
        end else begin
            regRdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_rai_follows_loss: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (netLos || netLof) |=> netRaiTx)
        else $error("remote alarm not sent on loss");
    a_cts_on_loss: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (netLos || netLof) |=> !dteCts)
        else $error("cts asserted during loss");
    a_rlsd_on_ais: assert property (@(posedge clk_sys) disable iff (!rst_b)
        netAis |=> !dteRlsd)
        else $error("rlsd asserted during all-ones");
    a_rai_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (netRaiRx && !ctrl[eal_pkg::C_YELLOW_EN] && !netLos && !netLof && !dteLost) |=> dteCts)
        else $error("disabled remote alarm dropped cts");
    a_test_unlimited: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (testState == EAL_RUN && testLen == eal_pkg::TLEN_UNL && !testStop) |=>
        testState == EAL_RUN)
        else $error("unlimited test ended");
    a_loopup_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(netLoopback) |-> $past(ctrl[eal_pkg::C_ALT_CODE] ? netLoopupAlt : netLoopupStd))
        else $error("loopback without matching code");
    a_payload_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(payloadLoopback) |-> $past(ctrl[eal_pkg::C_V54_EN] && payloadHasBw))
        else $error("payload loopback not qualified");
    a_cts_none_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (dteMode == eal_pkg::DTE_NONE && !netLos && !netLof && !raiSeen) |=> dteCts)
        else $error("cts dropped in none mode");
    a_dial_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(dialReq) |-> $past(ctrl[eal_pkg::C_MODEM] && !ctrl[eal_pkg::C_BLOCK_ALL]))
        else $error("dial without modem or with blocking");
    a_lamp_all_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ctrl[eal_pkg::C_LAMP] |=> ledOut == {LED_W{1'b1}})
        else $error("lamp test not all on");
endmodule // eal_ctrl

`default_nettype wire

// file: bench/eal_far_end.sv
// Purpose: far-end model: network line conditions and alarm modem
// Assumes: bench sets the line conditions on clk_sys
// Notes: modem answers each dial request after dialDelay+1 clocks
`timescale 1ns/1ps
`default_nettype none
module eal_far_end (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // bench controls
    input wire logic [3:0] alarmReq,
    input wire logic [3:0] dialDelay,
    // network line
    output logic netLos,
    output logic netLof,
    output logic netAis,
    output logic netRaiRx,
    // modem
    input wire logic dialReq,
    input wire logic dialNumSel,
    output logic dialDone,
    output logic [1:0] numSeen
);
    logic [3:0] waitCnt;
    // line conditions follow the bench request
    assign {netRaiRx, netAis, netLof, netLos} = alarmReq;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            waitCnt <= 4'h0;
            dialDone <= 1'b0;
            numSeen <= 2'h0;
        end else begin
            dialDone <= 1'b0;
            if (!dialReq || dialDone) begin
                waitCnt <= 4'h0;
            end else if (waitCnt == dialDelay) begin
                dialDone <= 1'b1;
                numSeen[dialNumSel] <= 1'b1;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule // eal_far_end
`default_nettype wire

// file: bench/e1_alarm_loopback_control_test.sv
// Purpose: self-checking bench for the alarm and loopback control block
// Assumes: test minute shortened to MINC clocks
// Notes: reset and unmapped reads first, then table of alarm cases, then hand-written checks
`timescale 1ns/1ps
`default_nettype none
module e1_alarm_loopback_control_test;
    localparam int MINC = 10;
    // rows: {rai ais lof los hi-first, raiTx, cts, rlsd, rlsd checked}
    localparam logic [7:0] ROWS [5] = '{8'h07, 8'h18, 8'h28, 8'h45, 8'h83};
    // dte rows: {mode, rts, dtr, cts}
    localparam logic [4:0] DROWS [5] = '{5'h01, 5'h0A, 5'h0D, 5'h14, 5'h13};
    localparam logic [1:0] TLEN [3] = '{2'h1, 2'h0, 2'h2};
    localparam int TMIN [3] = '{1, 15, 60};
    logic clk_sys, rst_b, regWr, regRd, irq, netLoopupStd, netLoopupAlt, netLoopdown;
    logic netV54Up, netV54Down, payloadHasBw, crcErr, codeViol, dteRts, dteDtr, dteCts;
    logic dteRlsd, netRaiTx, netLoopback, payloadLoopback, dialReq, dialNumSel, dialDone;
    logic testActive, netLos, netLof, netAis, netRaiRx;
    logic [7:0] regAddr, ledOut, ledNormal;
    logic [31:0] regWdata, regRdata;
    logic [1:0] txTimingSel, numSeen;
    logic [3:0] alarmReq, dialDelay;
    int err_total, comparisons;

    eal_ctrl #(.MIN_CYCLES(MINC), .LED_W(8)) uut (.clk_sys, .rst_b, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .irq, .netLos, .netLof, .netAis, .netRaiRx, .netLoopupStd,
        .netLoopupAlt, .netLoopdown, .netV54Up, .netV54Down, .payloadHasBw, .crcErr,
        .codeViol, .dteRts, .dteDtr, .dteCts, .dteRlsd, .netRaiTx, .netLoopback,
        .payloadLoopback, .txTimingSel, .dialReq, .dialNumSel, .dialDone, .ledOut,
        .ledNormal, .testActive);
    eal_far_end far (.clk_sys, .rst_b, .alarmReq, .dialDelay, .netLos, .netLof, .netAis,
        .netRaiRx, .dialReq, .dialNumSel, .dialDone, .numSeen);

    // clock source
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(nm, regRdata, exp);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        step(20000);
        err_total++;
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {regAddr, regWdata, regWr, regRd, netLoopupStd, netLoopupAlt, netLoopdown} = '0;
        {netV54Up, netV54Down, payloadHasBw, crcErr, codeViol, alarmReq} = '0;
        {dteRts, dteDtr, ledNormal, dialDelay} = {2'b11, 8'h5A, 4'h2};
        err_total = 0;
        comparisons = 0;
        rst_b = 1'b0;
        step(6);
        rst_b <= 1'b1;
        rdc("ctrl", eal_pkg::ADDR_CTRL, eal_pkg::CTRL_RESET);
        rdc("tod", eal_pkg::ADDR_TOD, 32'h0);
        rdc("date", eal_pkg::ADDR_DATE, 32'h0001_0101);
        wr(8'h20, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h20, 32'h0);
        // alarm table
        foreach (ROWS[i]) begin
            @(posedge clk_sys);
            alarmReq <= ROWS[i][7:4];
            step(3);
            #1 chk("raiTx", netRaiTx, ROWS[i][3]);
            chk("cts", dteCts, ROWS[i][2]);
            if (ROWS[i][0]) chk("rlsd", dteRlsd, ROWS[i][1]);
            rdc("nstat", eal_pkg::ADDR_NSTAT, {28'h0, ROWS[i][7:4]});
        end
        wr(eal_pkg::ADDR_CTRL, 32'h3C08);
        step(3);
        #1 chk("cts rai off", dteCts, 1'b1);
        rdc("nstat rai off", eal_pkg::ADDR_NSTAT, 32'h0);
        @(posedge clk_sys);
        alarmReq <= 4'h0;
        wr(eal_pkg::ADDR_IRQ_STAT, 32'hFF);
        rdc("stat clear", eal_pkg::ADDR_IRQ_STAT, 32'h0);
        // interrupt raised, cleared, then masked
        wr(eal_pkg::ADDR_IRQ_MASK, 32'h1);
        @(posedge clk_sys);
        alarmReq <= 4'h1;
        step(3);
        #1 chk("irq los", irq, 1'b1);
        wr(eal_pkg::ADDR_IRQ_STAT, 32'h1);
        step(2);
        #1 chk("irq clear", irq, 1'b0);
        @(posedge clk_sys);
        alarmReq <= 4'h2;
        step(3);
        #1 chk("irq masked", irq, 1'b0);
        rdc("stat lof", eal_pkg::ADDR_IRQ_STAT, 32'h2);
        @(posedge clk_sys);
        alarmReq <= 4'h0;
        wr(eal_pkg::ADDR_IRQ_STAT, 32'hFF);
        wr(eal_pkg::ADDR_CTRL, 32'h7C09);
        step(2);
        #1 chk("lamp", ledOut, 8'hFF);
        wr(eal_pkg::ADDR_CTRL, 32'h3C09);
        step(2);
        #1 chk("led normal", ledOut, 8'h5A);
        for (int t = 0; t < 3; t++) begin
            wr(eal_pkg::ADDR_CTRL, 32'h3C09 | (t << 5));
            step(2);
            #1 chk("timing", txTimingSel, t[1:0]);
        end
        foreach (DROWS[i]) begin
            wr(eal_pkg::ADDR_CTRL, 32'h3C01 | (DROWS[i][4:3] << 3));
            {dteRts, dteDtr} <= DROWS[i][2:1];
            step(3);
            #1 chk("cts dte", dteCts, DROWS[i][0]);
        end
        {dteRts, dteDtr} <= 2'b11;
        for (int k = 0; k < 4; k++) begin
            wr(eal_pkg::ADDR_CTRL, 32'h3C09 | (k[1] << 1));
            {netLoopupAlt, netLoopupStd} <= k[0] ? 2'b10 : 2'b01;
            step(3);
            {netLoopupAlt, netLoopupStd} <= 2'b00;
            #1 chk("netlpbk", netLoopback, k[0] == k[1]);
            @(posedge clk_sys);
            netLoopdown <= 1'b1;
            @(posedge clk_sys);
            netLoopdown <= 1'b0;
            step(2);
            #1 chk("netlpbk down", netLoopback, 1'b0);
        end
        for (int j = 0; j < 3; j++) begin
            wr(eal_pkg::ADDR_CTRL, 32'h3C09 | ((j > 0) << 2));
            payloadHasBw <= (j != 1);
            netV54Up <= 1'b1;
            @(posedge clk_sys);
            netV54Up <= 1'b0;
            step(2);
            #1 chk("pllpbk", payloadLoopback, j == 2);
        end
        @(posedge clk_sys);
        netV54Down <= 1'b1;
        @(posedge clk_sys);
        netV54Down <= 1'b0;
        step(2);
        #1 chk("pllpbk down", payloadLoopback, 1'b0);
        for (int m = 0; m < 2; m++) begin
            wr(eal_pkg::ADDR_CTRL, 32'h3C09 | (m << 7));
            wr(eal_pkg::ADDR_ERRCNT, 32'h0);
            for (int p = 0; p < 5; p++) begin
                {crcErr, codeViol} <= (p < 3) ? 2'b10 : 2'b01;
                @(posedge clk_sys);
                {crcErr, codeViol} <= 2'b00;
                @(posedge clk_sys);
            end
            rdc("errcnt", eal_pkg::ADDR_ERRCNT, m ? 32'h5 : 32'h2);
        end
        wr(eal_pkg::ADDR_CTRL, 32'h3C09);
        wr(eal_pkg::ADDR_IRQ_STAT, 32'hFF);
        wr(eal_pkg::ADDR_IRQ_MASK, 32'h10);
        foreach (TLEN[i]) begin
            wr(eal_pkg::ADDR_TEST, {28'h0, TLEN[i], 2'b01});
            step(TMIN[i] * MINC - 3);
            #1 chk("test running", testActive, 1'b1);
            step(6);
            #1 chk("test ended", testActive, 1'b0);
            chk("irq test end", irq, 1'b1);
            wr(eal_pkg::ADDR_IRQ_STAT, 32'h10);
        end
        wr(eal_pkg::ADDR_TEST, 32'hD);
        step(700);
        #1 chk("unlimited", testActive, 1'b1);
        rdc("test reg", eal_pkg::ADDR_TEST, 32'h3F0D);
        wr(eal_pkg::ADDR_TEST, 32'h2);
        step(3);
        #1 chk("stopped", testActive, 1'b0);
        chk("irq cleared", irq, 1'b0);
        // dial-out gates, then a slow modem on both numbers
        wr(eal_pkg::ADDR_IRQ_MASK, 32'h0);
        for (int g = 0; g < 3; g++) begin
            wr(eal_pkg::ADDR_CTRL, (g == 0) ? 32'h3F09 : (g == 1) ? 32'h3909 : 32'h3C09);
            alarmReq <= 4'h1;
            step(4);
            #1 chk("no dial", dialReq, 1'b0);
            @(posedge clk_sys);
            alarmReq <= 4'h0;
        end
        dialDelay <= 4'h8;
        wr(eal_pkg::ADDR_CTRL, 32'h3D09);
        alarmReq <= 4'h1;
        step(2);
        #1 chk("dial", dialReq, 1'b1);
        chk("first number", dialNumSel, 1'b0);
        rdc("nstat dialing", eal_pkg::ADDR_NSTAT, 32'h21);
        for (int w = 0; w < 60 && dialReq; w++) @(posedge clk_sys);
        step(2);
        #1 chk("dial over", dialReq, 1'b0);
        chk("both numbers", numSeen, 2'b11);
        // defaults again after a second reset
        wr(eal_pkg::ADDR_TOD, 32'h1234_5678);
        rdc("tod rw", eal_pkg::ADDR_TOD, 32'h1234_5678);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        alarmReq <= 4'h0;
        step(2);
        rst_b <= 1'b1;
        rdc("tod again", eal_pkg::ADDR_TOD, 32'h0);
        rdc("date again", eal_pkg::ADDR_DATE, 32'h0001_0101);
        complete_run();
    end
endmodule // e1_alarm_loopback_control_test
`default_nettype wire
